// ---- testbench/nbw_flash_model.sv ----
// Purpose: Behavioural flash device facing nbw_host
// Assumes: Commands latch on the strobe rising edge
// Notes:   Bench sets busy length for fast and slow answers
module nbw_flash_model
   import nbw_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire logic       cleOut,
   input  wire logic       weNOut,
   input  wire logic       reNOut,
   input  wire logic       wpNOut,
   input  wire logic [7:0] ioOut,
   input  wire logic [7:0] busyLen,
   output logic            pullLow,
   output logic [7:0]      ioIn,
   output int              nEv,
   output int              nBad
);
   logic [7:0] left;
   logic       weLast;
   logic       prgEra;
   logic       tog;
   assign pullLow = (left != 8'h00);
   // Ready on bit six; idle bus toggles so stale data never reads back
   assign ioIn = reNOut ? ({8{tog}} ^ 8'hA5) : {1'b1, ~pullLow, 6'h00};
   always @(posedge sys_clk or negedge rstn)
      if (!rstn)
      begin
         left   <= 8'h1E;
         weLast <= 1'b1;
         prgEra <= 1'b0;
         tog    <= 1'b0;
         nEv    <= 0;
         nBad   <= 0;
      end
      else
      begin
         tog    <= ~tog;
         weLast <= weNOut;
         if (left != 8'h00)
            left <= left - 8'h01;
         if (pullLow && prgEra && !wpNOut)
            nBad <= nBad + 1;
         if (weNOut && !weLast && cleOut)
         begin
            if (pullLow && ioOut != CMD_STATUS)
               nBad <= nBad + 1;
            // Program or erase starts unless guarded
            else if ((ioOut == CMD_PROG_GO || ioOut == CMD_ERAS_GO) && wpNOut)
            begin
               left   <= busyLen;
               prgEra <= 1'b1;
               nEv    <= nEv + 1;
            end
            // Read goes busy after address load
            else if (ioOut == CMD_READ_GO)
            begin
               left   <= busyLen;
               prgEra <= 1'b0;
               nEv    <= nEv + 1;
            end
         end
      end
endmodule // nbw_flash_model

// ---- testbench/nbw_host_checker.sv ----
// Purpose: Port-level assertions for nbw_host
// Assumes: Single sys_clk domain
// Notes:   Attached by bind below
module nbw_host_checker
   import nbw_pkg::*;
#(
   parameter int ADDR_BYTES = 5
)
(
   input wire logic       sys_clk,
   input wire logic       rstn,
   input wire logic       opStart,
   input wire logic [1:0] opKind,
   input wire logic       rbIn,
   input wire logic [7:0] ioOut,
   input wire logic       cleOut,
   input wire logic       weNOut,
   input wire logic       wpNOut,
   input wire logic       opDone,
   input wire logic       opBusy,
   input wire logic       devReady,
   input wire logic       opRefused
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   AST_WE_PULSE: assert property ($fell(weNOut) |=> !weNOut ##1 weNOut)
      else $error("write strobe width wrong");
   AST_BUSY_CLEAR: assert property (opDone |-> ##[0:1] !opBusy)
      else $error("busy kept after done");
   AST_DONE_READY: assert property (opDone |-> devReady)
      else $error("done while line busy");
   AST_REFUSE: assert property (opRefused |-> !devReady)
      else $error("refusal outside init");
   AST_INIT_STATUS: assert property ($fell(weNOut) && cleOut && !devReady |-> ioOut == CMD_STATUS)
      else $error("non-status command while busy");
   AST_WP_BUSY: assert property (wpNOut && !rbIn |=> wpNOut)
      else $error("write-protect lowered while busy");
   AST_WP_PROG: assert property (opStart && !opBusy && opKind == OP_PROG |=> wpNOut)
      else $error("program without write enable");
   AST_WP_ERASE: assert property (opStart && !opBusy && opKind == OP_ERASE |=> wpNOut)
      else $error("erase without write enable");
   AST_WP_IDLE: assert property (wpNOut |-> opBusy)
      else $error("write-protect released while idle");
   cover property (opRefused);
   cover property (opStart && opKind == OP_ERASE);
   cover property ($fell(weNOut) && cleOut && ioOut == CMD_STATUS);
endmodule // nbw_host_checker
bind nbw_host nbw_host_checker #(.ADDR_BYTES(ADDR_BYTES)) nbw_host_checker_i (.sys_clk(sys_clk), .rstn(rstn),
   .opStart(opStart), .opKind(opKind), .rbIn(rbIn), .ioOut(ioOut), .cleOut(cleOut), .weNOut(weNOut),
   .wpNOut(wpNOut), .opDone(opDone), .opBusy(opBusy), .devReady(devReady), .opRefused(opRefused));

// ---- testbench/nbw_host_tb_top.sv ----
// Purpose: Self-checking bench for nbw_host
// Assumes: 40 MHz clock, device model on the far side
// Notes:   Outputs sampled at the edge, before its updates land
module nbw_host_tb_top
   import nbw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic       sys_clk, rstn, opStart, usePoll, extPull, pullLow;
   logic [1:0] opKind;
   logic [7:0] busyLen, ioIn, ioOut;
   logic       ioOe, cleOut, aleOut, weNOut, reNOut, wpNOut;
   logic       opDone, opBusy, devReady, opRefused;
   int         nEv, nBad, errTotal, nChecks, n;
   // Wired line: any party pulling low means busy
   wire logic  rbIn = !(pullLow || extPull);
   nbw_host nbw_host_i (.sys_clk(sys_clk), .rstn(rstn), .opStart(opStart), .opKind(opKind),
      .usePoll(usePoll), .rbIn(rbIn), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .cleOut(cleOut),
      .aleOut(aleOut), .weNOut(weNOut), .reNOut(reNOut), .wpNOut(wpNOut), .opDone(opDone),
      .opBusy(opBusy), .devReady(devReady), .opRefused(opRefused));
   nbw_flash_model nbw_flash_model_i (.sys_clk(sys_clk), .rstn(rstn), .cleOut(cleOut), .weNOut(weNOut),
      .reNOut(reNOut), .wpNOut(wpNOut), .ioOut(ioOut), .busyLen(busyLen), .pullLow(pullLow),
      .ioIn(ioIn), .nEv(nEv), .nBad(nBad));
   // Free-running clock
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      nChecks++;
      if (got !== exp)
      begin
         errTotal++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // One operation; wait bounded for done, then judge the outcome
   task automatic t_op(input string nm, input logic [1:0] k, input logic p, input int ev, input logic [7:0] bl);
      int e0;
      int nAdr;
      logic wpHi;
      logic wePrev;
      logic reLo;
      logic oeBad;
      e0 = nEv;
      nAdr = 0;
      wpHi = 1'b0;
      wePrev = 1'b1;
      reLo = 1'b0;
      oeBad = 1'b0;
      n = 0;
      busyLen <= bl;
      opKind <= k;
      usePoll <= p;
      opStart <= 1'b1;
      @(posedge sys_clk);
      opStart <= 1'b0;
      while (opDone !== 1'b1 && n < 3000)
      begin
         @(posedge sys_clk);
         wpHi = wpHi | wpNOut;
         // Address byte latched on strobe rise while address latch enable is high
         if (weNOut && !wePrev && aleOut)
            nAdr++;
         if (!weNOut && !ioOe)
            oeBad = 1'b1;
         reLo = reLo | !reNOut;
         wePrev = weNOut;
         n++;
      end
      chk(opDone, 1'b1);
      chk(16'(nEv - e0), 16'(ev));
      chk(wpHi, k == OP_PROG || k == OP_ERASE);
      chk(16'(nBad), 16'h0000);
      chk(16'(nAdr), (k == OP_POLL) ? 16'h0000 : ((k == OP_ERASE) ? 16'h0003 : 16'h0005));
      chk(oeBad, 1'b0);
      chk(reLo, p);
      repeat (2) @(posedge sys_clk);
      chk({wpNOut, opBusy}, 2'b00);
      $display("[END] %s t=%0t", nm, $time);
   endtask
   // Non-status request during power-up must be refused
   task automatic t_init();
      logic seen;
      seen = 1'b0;
      opKind <= OP_READ;
      opStart <= 1'b1;
      @(posedge sys_clk);
      opStart <= 1'b0;
      repeat (4)
      begin
         @(posedge sys_clk);
         seen = seen | opRefused;
      end
      chk(seen, 1'b1);
      for (n = 5; n < 200 && devReady !== 1'b1; n++)
         @(posedge sys_clk);
      chk(n > 25, 1'b1);
      chk(16'(nEv), 16'h0000);
      @(posedge sys_clk);
      $display("[END] init t=%0t", $time);
   endtask
   // Second party holds the shared line low after the device is done
   task automatic t_shared();
      fork
         t_op("shared", OP_READ, 1'b0, 1, 8'h28);
         begin
            repeat (45) @(posedge sys_clk);
            extPull <= 1'b1;
            repeat (105) @(posedge sys_clk);
            extPull <= 1'b0;
         end
      join
      chk(n > 150, 1'b1);
   endtask
   // Main sequence
   initial
   begin
      rstn = 1'b0;
      opStart = 1'b0;
      opKind = 2'd0;
      usePoll = 1'b0;
      extPull = 1'b0;
      busyLen = 8'h03;
      errTotal = 0;
      nChecks = 0;
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      t_init();
      t_op("read", OP_READ, 1'b0, 1, 8'h03);
      t_op("prog", OP_PROG, 1'b0, 1, 8'h28);
      t_op("erase", OP_ERASE, 1'b0, 1, 8'h03);
      t_op("poll", OP_POLL, 1'b0, 0, 8'h03);
      t_op("readpoll", OP_READ, 1'b1, 1, 8'h28);
      t_op("erasepoll", OP_ERASE, 1'b1, 1, 8'h28);
      t_shared();
      complete_run();
   end
   // Watchdog: far beyond the expected run length
   initial
   begin
      #500000;
      errTotal++;
      complete_run();
   end
endmodule // nbw_host_tb_top

// ---- verilog/nbw_byte_strobe.sv ----
// Purpose: Drives one command/address byte onto the bus with a write strobe
// Assumes: Bus owned by this module while busy
// Notes:   Strobe low for STROBE_CYC, then high for STROBE_CYC
module nbw_byte_strobe
   import nbw_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire logic       start,
   input  wire logic [7:0] byteIn,
   output logic            weN,
   output logic [7:0]      dataOut,
   output logic            done
);

   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic             run_q, run_d;
   logic             weN_q, weN_d;
   logic [7:0]       dat_q, dat_d;
   logic             done_q, done_d;

   // Two-phase strobe sequencing
   always_comb
   begin
      cnt_d  = cnt_q;
      run_d  = run_q;
      weN_d  = weN_q;
      dat_d  = dat_q;
      done_d = 1'b0;
      if (!run_q && start)
      begin
         run_d = 1'b1;
         weN_d = 1'b0;
         dat_d = byteIn;
         cnt_d = CNT_W'(2 * STROBE_CYC - 1);
      end
      else if (run_q)
      begin
         if (cnt_q == CNT_W'(STROBE_CYC))
            weN_d = 1'b1;   // Rising edge latches the byte in the device
         if (cnt_q == '0)
         begin
            run_d  = 1'b0;
            done_d = 1'b1;
         end
         else
            cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_q  <= '0;
         run_q  <= 1'b0;
         weN_q  <= 1'b1;
         dat_q  <= 8'h00;
         done_q <= 1'b0;
      end
      else
      begin
         cnt_q  <= cnt_d;
         run_q  <= run_d;
         weN_q  <= weN_d;
         dat_q  <= dat_d;
         done_q <= done_d;
      end
   end

   assign weN     = weN_q;
   assign dataOut = dat_q;
   assign done    = done_q;

endmodule // nbw_byte_strobe

// ---- verilog/nbw_host.sv ----
// What this block does
// [RULE1] Device goes busy after program/erase command
// [RULE2] Device goes busy after read address load
// [RULE3] Device returns ready when operation completes
// [RULE4] Shared open-drain line: any low means busy
// [RULE5] Device initializes once supply is adequate
// [RULE6] Device busy throughout power-up initialization
// [RULE7] Only status command during initialization
// [RULE8] Never assert write-protect while device busy
// [RULE9] Hold write-protect high until program finishes
// [RULE10] Hold write-protect high until erase finishes
// [RULE11] Write-protect guards data at power transitions
// [RULE12] Status bit six polling replaces busy pin
// [RULE13] Protected device refuses program and erase
//
// Purpose: Host sequencer that issues read/program/erase/status commands to a
//          NAND device, tracks its ready/busy line and drives write-protect.
// Assumes: Inputs synchronous to sys_clk; address bytes are sent as zero, data phase not covered here.
// Notes:   Command byte goes out through nbw_byte_strobe.
module nbw_host
   import nbw_pkg::*;
#(
   parameter int ADDR_BYTES = 5
)
(
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire logic       opStart,
   input  wire logic [1:0] opKind,
   input  wire logic       usePoll,
   input  wire logic       rbIn,
   input  wire logic [7:0] ioIn,
   output logic [7:0]      ioOut,
   output logic            ioOe,
   output logic            cleOut,
   output logic            aleOut,
   output logic            weNOut,
   output logic            reNOut,
   output logic            wpNOut,
   output logic            opDone,
   output logic            opBusy,
   output logic            devReady,
   output logic            opRefused
);

   if (ADDR_BYTES < 1 || ADDR_BYTES > 8)
   begin : gAddrBytesCheck
      $error("ADDR_BYTES out of range");
   end

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [7:0] {
      ST_INIT  = 8'b0000_0001,
      ST_IDLE  = 8'b0000_0010,
      ST_CMD1  = 8'b0000_0100,
      ST_ADDR  = 8'b0000_1000,
      ST_CMD2  = 8'b0001_0000,
      ST_SETL  = 8'b0010_0000,
      ST_WAIT  = 8'b0100_0000,
      ST_DONE  = 8'b1000_0000
   } nbw_state_t;

   nbw_state_t       st_q, st_d;
   logic [1:0]       kind_q, kind_d;
   logic             poll_q, poll_d;
   logic [3:0]       abyte_q, abyte_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic             strobeGo;
   logic [7:0]       strobeByte;
   logic             strobeDone;
   logic [7:0]       strobeData;
   logic             strobeWe;
   logic             cle_q, cle_d, ale_q, ale_d, oe_q, oe_d;
   logic             re_q, re_d, wp_q, wp_d;
   logic             done_q, done_d, busy_q, busy_d, ref_q, ref_d, rdy_q, rdy_d;

   // First command of each operation kind
   function automatic logic [7:0] firstCmd(input logic [1:0] k);
      case (k)
         OP_PROG:  firstCmd = CMD_PROG_SET;
         OP_ERASE: firstCmd = CMD_ERAS_SET;
         OP_POLL:  firstCmd = CMD_STATUS;
         default:  firstCmd = CMD_READ_SET;
      endcase
   endfunction

   function automatic logic [7:0] secondCmd(input logic [1:0] k);
      case (k)
         OP_PROG:  secondCmd = CMD_PROG_GO;
         OP_ERASE: secondCmd = CMD_ERAS_GO;
         default:  secondCmd = CMD_READ_GO;
      endcase
   endfunction

   // Device ready: pin high, or status bit six when polling
   function automatic logic isReady(input logic poll, input logic rb, input logic [7:0] io);
      isReady = poll ? io[STATUS_READY_BIT] : rb;
   endfunction

   // ----------------------------------------------------------------
   // Byte strobe engine
   // ----------------------------------------------------------------
   nbw_byte_strobe u_strobe (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .start   (strobeGo),
      .byteIn  (strobeByte),
      .weN     (strobeWe),
      .dataOut (strobeData),
      .done    (strobeDone)
   );

   // Byte to present for the current phase; address bytes are zero here
   always_comb
   begin
      strobeByte = 8'h00;
      // A byte is launched only in the first cycle of its phase
      strobeGo   = (st_q == ST_CMD1 || st_q == ST_ADDR || st_q == ST_CMD2) && (cnt_q == '0);
      case (st_q)
         ST_CMD1: strobeByte = firstCmd(kind_q);
         ST_CMD2: strobeByte = secondCmd(kind_q);
         default: strobeByte = 8'h00;
      endcase
   end

   // Next-state logic for the sequencer
   always_comb
   begin
      st_d    = st_q;
      kind_d  = kind_q;
      poll_d  = poll_q;
      abyte_d = abyte_q;
      cnt_d   = cnt_q;
      cle_d   = 1'b0;
      ale_d   = 1'b0;
      oe_d    = 1'b0;
      re_d    = 1'b1;
      wp_d    = wp_q;
      done_d  = 1'b0;
      ref_d   = 1'b0;
      busy_d  = busy_q;
      // [RULE4] Wired line sampling
      rdy_d   = rbIn;
      case (st_q)
         // [RULE6] Wait out power-up busy
         ST_INIT:
         begin
            busy_d = 1'b1;
            // [RULE11] Protect during power-up
            wp_d   = 1'b0;
            // [RULE5] Begin once line released
            if (rbIn)
            begin
               st_d   = ST_IDLE;
               busy_d = 1'b0;
            end
            // [RULE7] Only status allowed here
            else if (opStart && opKind != OP_POLL)
               ref_d = 1'b1;
         end
         ST_IDLE:
         begin
            wp_d = 1'b0;  // Protected whenever nothing is being written
            if (opStart)
            begin
               kind_d = opKind;
               poll_d = usePoll;
               cnt_d  = '0;
               busy_d = 1'b1;
               // [RULE9] Unprotect before program
               // [RULE10] Unprotect before erase
               if (opKind == OP_PROG || opKind == OP_ERASE)
                  wp_d = 1'b1;
               abyte_d = (opKind == OP_ERASE) ? 4'd3 : 4'(ADDR_BYTES);
               st_d    = ST_CMD1;
            end
         end
         ST_CMD1:
         begin
            cle_d = 1'b1;
            oe_d  = 1'b1;
            cnt_d = CNT_W'(1);
            if (strobeDone)
            begin
               cnt_d = '0;
               st_d  = (kind_q == OP_POLL) ? ST_SETL : ST_ADDR;
            end
         end
         ST_ADDR:
         begin
            ale_d = 1'b1;
            oe_d  = 1'b1;
            cnt_d = CNT_W'(1);
            if (strobeDone)
            begin
               cnt_d   = '0;
               abyte_d = abyte_q - 4'd1;
               if (abyte_q == 4'd1)
                  st_d = ST_CMD2;
            end
         end
         ST_CMD2:
         begin
            cle_d = 1'b1;
            oe_d  = 1'b1;
            cnt_d = CNT_W'(1);
            if (strobeDone)
            begin
               // [RULE1] [RULE2] Busy follows confirm byte
               cnt_d = CNT_W'(WB_CYC);
               st_d  = ST_SETL;
            end
         end
         ST_SETL:
         begin
            // Device needs time to pull the line low before it means anything
            if (cnt_q == '0)
               st_d = ST_WAIT;
            else
               cnt_d = cnt_q - 1'b1;
         end
         ST_WAIT:
         begin
            re_d = !poll_q;  // Status byte read with read strobe held low
            // [RULE3] [RULE12] Done on ready; bus trusted only once read strobe is low
            if (isReady(poll_q, rbIn, ioIn) && (!poll_q || !re_q))
               st_d = ST_DONE;
         end
         ST_DONE:
         begin
            // [RULE8] Assert protect (write-protect low) only after ready
            wp_d   = 1'b0;
            busy_d = 1'b0;
            done_d = 1'b1;
            // [RULE13] Protected device stays ready
            st_d   = ST_IDLE;
         end
         default: st_d = ST_INIT;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_q    <= ST_INIT;
         kind_q  <= OP_READ;
         poll_q  <= 1'b0;
         abyte_q <= 4'd0;
         cnt_q   <= '0;
         cle_q   <= 1'b0;
         ale_q   <= 1'b0;
         oe_q    <= 1'b0;
         re_q    <= 1'b1;
         wp_q    <= 1'b0;
         done_q  <= 1'b0;
         busy_q  <= 1'b1;
         ref_q   <= 1'b0;
         rdy_q   <= 1'b0;
      end
      else
      begin
         st_q    <= st_d;
         kind_q  <= kind_d;
         poll_q  <= poll_d;
         abyte_q <= abyte_d;
         cnt_q   <= cnt_d;
         cle_q   <= cle_d;
         ale_q   <= ale_d;
         oe_q    <= oe_d;
         re_q    <= re_d;
         wp_q    <= wp_d;
         done_q  <= done_d;
         busy_q  <= busy_d;
         ref_q   <= ref_d;
         rdy_q   <= rdy_d;
      end
   end

   // Outputs straight from flip-flops (strobe and data from the engine's)
   assign ioOut     = strobeData;
   assign ioOe      = oe_q;
   assign cleOut    = cle_q;
   assign aleOut    = ale_q;
   assign weNOut    = strobeWe;
   assign reNOut    = re_q;
   assign wpNOut    = wp_q;
   assign opDone    = done_q;
   assign opBusy    = busy_q;
   assign devReady  = rdy_q;
   assign opRefused = ref_q;

endmodule // nbw_host

// ---- verilog/nbw_pkg.sv ----
// Purpose: Shared constants for the NAND busy / write-guard host controller
// Assumes: 40 MHz sys_clk
// Notes:   Command codes and timing figures used by the host sequencer
package nbw_pkg;

   // ----------------------------------------------------------------
   // Commands
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_STATUS   = 8'h70;
   localparam logic [7:0] CMD_PROG_SET = 8'h80;
   localparam logic [7:0] CMD_PROG_GO  = 8'h10;
   localparam logic [7:0] CMD_ERAS_SET = 8'h60;
   localparam logic [7:0] CMD_ERAS_GO  = 8'hD0;
   localparam logic [7:0] CMD_READ_SET = 8'h00;
   localparam logic [7:0] CMD_READ_GO  = 8'h30;

   // Status bit that reports ready
   localparam int STATUS_READY_BIT = 6;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ        = 40;
   localparam int STROBE_NS      = 50;
   localparam int STROBE_CYC     = (STROBE_NS * CLK_MHZ + 999) / 1000;
   // Settle time between command write and first busy sample
   localparam int WB_NS          = 100;
   localparam int WB_CYC         = (WB_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W          = 8;

   // Operation kinds
   localparam logic [1:0] OP_READ  = 2'd0;
   localparam logic [1:0] OP_PROG  = 2'd1;
   localparam logic [1:0] OP_ERASE = 2'd2;
   localparam logic [1:0] OP_POLL  = 2'd3;

endpackage : nbw_pkg
